// *** dv/host_ctrl_model.sv ***
/* Host controller model: register strobes, power commands, modes.
   Changes its outputs only at the falling edge of ref_clk. */
`timescale 1ns/100ps
module host_ctrl_model
    import fault_timer_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic [7:0]  reg_rdata,
    output logic [7:0]       reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_wdata,
    output logic [PORTS-1:0] power_on_cmd,
    output logic [PORTS-1:0] power_off_cmd,
    output logic [PORTS-1:0] auto_mode,
    output logic [PORTS-1:0] detect_good,
    output logic [PORTS-1:0] port_shutdown
);
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
        {power_on_cmd, power_off_cmd, detect_good} = '0;
        {auto_mode, port_shutdown} = '0;
    end
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released lines show a changed value, not the stale one.
        reg_addr = ~a;
        reg_wdata = ~d;
        @(negedge ref_clk);
        q = reg_rdata;
    endtask
    task automatic cmd(input logic [2:0] sel, input logic [PORTS-1:0] m);
        @(negedge ref_clk);
        power_on_cmd = sel[0] ? m : '0;
        power_off_cmd = sel[1] ? m : '0;
        detect_good = sel[2] ? m : '0;
        @(negedge ref_clk);
        {power_on_cmd, power_off_cmd, detect_good} = '0;
    endtask
    task automatic set_modes(input logic [PORTS-1:0] am,
                             input logic [PORTS-1:0] sd);
        @(negedge ref_clk);
        auto_mode = am;
        port_shutdown = sd;
    endtask
endmodule // host_ctrl_model

// *** dv/port_fault_timers_chk.sv ***
/* Assertions on the port_fault_timers ports.
   Bound into the design from the bench top file. */
`timescale 1ns/100ps
module port_fault_timers_chk
    import fault_timer_pkg::*;
#(
    parameter int N         = PORTS,
    parameter int GATE_HOLD = GATE_HOLD_CYC
) (
    input wire logic         ref_clk,
    input wire logic         arst_n,
    input wire logic [7:0]   reg_addr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_rdata,
    input wire logic [N-1:0] power_on_cmd,
    input wire logic [N-1:0] power_off_cmd,
    input wire logic [N-1:0] auto_mode,
    input wire logic [N-1:0] detect_good,
    input wire logic [N-1:0] short_circuit,
    input wire logic [N-1:0] port_power,
    input wire logic [N-1:0] gate_pull_down,
    input wire logic [N-1:0] undercurrent_timer_run
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_pw_rise(int k);
        !port_power[k] ##1 port_power[k];
    endsequence
    a_unmapped_zero: assert property (reg_rd && reg_addr != ADDR_FAULT_EVT
        && reg_addr != ADDR_DURATIONS |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    for (genvar i = 0; i < N; i++) begin : g_port
        logic [15:0] quiet_q;
        // Cycles since the last short on a powered port; saturates.
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n)
                quiet_q <= 16'hFFFF;
            else if (short_circuit[i] && port_power[i])
                quiet_q <= 16'h0000;
            else if (quiet_q != 16'hFFFF)
                quiet_q <= quiet_q + 16'h0001;
        end
        a_gate_fast: assert property (
            short_circuit[i] && port_power[i] |=> gate_pull_down[i])
            else $error("gate not pulled low");
        a_gate_hold: assert property (
            gate_pull_down[i] && quiet_q < GATE_HOLD - 2
            |=> gate_pull_down[i]) else $error("gate released early");
        a_gate_release: assert property (
            gate_pull_down[i] |-> quiet_q <= GATE_HOLD + 1)
            else $error("gate held too long");
        a_off_drops: assert property (
            power_off_cmd[i] |-> ##[1:2] !port_power[i])
            else $error("power off ignored");
        a_on_cause: assert property (
            $rose(port_power[i]) |-> $past(power_on_cmd[i]
            || auto_mode[i] && detect_good[i]))
            else $error("power without command");
        a_uc_idle: assert property (
            !port_power[i] |-> !undercurrent_timer_run[i])
            else $error("undercurrent timer runs unpowered");
        a_uc_powerup: assert property (
            s_pw_rise(i) |-> (!undercurrent_timer_run[i]) [*8])
            else $error("undercurrent timer runs in power-up");
    end
endmodule // port_fault_timers_chk

// *** dv/port_fault_timers_tb_top.sv ***
/* Bench top for port_fault_timers with host model and checker.
   Drives the current comparator levels itself at the falling edge. */
`timescale 1ns/100ps
module port_fault_timers_tb_top
    import fault_timer_pkg::*;
;
    localparam int TD  = 4;
    localparam int GH  = 8;
    localparam int PU  = (OVL_FULL_0 + STEP_SCALE) * TD;
    localparam int OV2 = (OVL_FULL_0 << 1) * TD;
    logic       ref_clk;
    logic       arst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       reg_wr, reg_rd;
    logic [3:0] power_on_cmd, power_off_cmd, auto_mode, detect_good;
    logic [3:0] port_shutdown, port_power, gate_pull_down;
    logic [3:0] undercurrent_timer_run, undercurrent_fault;
    logic [3:0] over_threshold = 4'h0;
    logic [3:0] at_hard_limit  = 4'h0;
    logic [3:0] short_circuit  = 4'h0;
    logic [3:0] under_current  = 4'h0;
    logic [3:0] disconnect_en  = 4'h0;
    int         n_errors       = 0;
    int         comparisons    = 0;
    port_fault_timers #(.TICK_DIV(TD), .GATE_HOLD(GH)) u_dut (.ref_clk,
        .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .power_on_cmd, .power_off_cmd, .auto_mode, .detect_good,
        .port_shutdown, .over_threshold, .at_hard_limit, .short_circuit,
        .under_current, .disconnect_en, .port_power, .gate_pull_down,
        .undercurrent_timer_run, .undercurrent_fault);
    host_ctrl_model u_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .power_on_cmd, .power_off_cmd, .auto_mode,
        .detect_good, .port_shutdown);
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
        logic [7:0] q;
        u_host.access(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] q;
        u_host.access(1'b1, a, d, q);
    endtask
    task automatic wait_pw(int p, logic v, int lim);
        int n = 0;
        while (port_power[p] !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        chk("port power", 8'(v), 8'(port_power[p]));
        if (port_power[p] !== v)
            final_report();
    endtask
    task automatic t_regs;
        rd(ADDR_FAULT_EVT, 8'h00, "fault reset");
        rd(ADDR_DURATIONS, DURATIONS_RST, "durations reset");
        wr(ADDR_DURATIONS, 8'h3C);
        rd(ADDR_DURATIONS, 8'h3C, "durations rw");
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00, "unmapped");
        wr(ADDR_DURATIONS, DURATIONS_RST);
        $display("t_regs done");
    endtask
    task automatic t_short;
        u_host.set_modes(4'h4, 4'h0);
        u_host.cmd(3'b100, 4'h4);
        wait_pw(2, 1'b1, 3);
        short_circuit[2] = 1'b1;
        cyc(1);
        chk("gate pulled", 8'h01, 8'(gate_pull_down[2]));
        short_circuit[2] = 1'b0;
        cyc(GH + 3);
        chk("gate freed", 8'h00, 8'(gate_pull_down[2]));
        u_host.cmd(3'b010, 4'h4);
        wait_pw(2, 1'b0, 3);
        u_host.set_modes(4'h0, 4'h0);
        $display("t_short done");
    endtask
    task automatic t_overload;
        wr(ADDR_DURATIONS, 8'h04);
        under_current[1] = 1'b1;
        disconnect_en[1] = 1'b1;
        u_host.cmd(3'b001, 4'h2);
        wait_pw(1, 1'b1, 3);
        cyc(PU / 2);
        chk("uc held", 8'h00, 8'(undercurrent_timer_run[1]));
        cyc(PU / 2 + 40);
        chk("uc runs", 8'h01, 8'(undercurrent_timer_run[1]));
        under_current[1] = 1'b0;
        rd(ADDR_FAULT_EVT, 8'h00, "no fault");
        over_threshold[1] = 1'b1;
        cyc(OV2 - 40);
        chk("on before trip", 8'h01, 8'(port_power[1]));
        wait_pw(1, 1'b0, 80);
        over_threshold[1] = 1'b0;
        rd(ADDR_FAULT_EVT, 8'h02, "overload bit");
        u_host.set_modes(4'h0, 4'h2);
        rd(ADDR_FAULT_EVT, 8'h00, "shutdown clears");
        u_host.set_modes(4'h0, 4'h0);
        wr(ADDR_DURATIONS, DURATIONS_RST);
        $display("t_overload done");
    endtask
    task automatic t_startup;
        over_threshold[0] = 1'b1;
        at_hard_limit[0] = 1'b1;
        u_host.cmd(3'b001, 4'h1);
        wait_pw(0, 1'b1, 3);
        cyc(PU - 40);
        chk("on in powerup", 8'h01, 8'(port_power[0]));
        wait_pw(0, 1'b0, 80);
        over_threshold[0] = 1'b0;
        at_hard_limit[0] = 1'b0;
        rd(ADDR_FAULT_EVT, 8'h10, "powerup bit");
        cyc(PU * 12);
        u_host.cmd(3'b001, 4'h1);
        cyc(2);
        chk("refused", 8'h00, 8'(port_power[0]));
        cyc(PU * 4 + 1000);
        rd(ADDR_FAULT_EVT, 8'h10, "bit sticky");
        u_host.cmd(3'b001, 4'h1);
        wait_pw(0, 1'b1, 3);
        u_host.cmd(3'b010, 4'h1);
        wait_pw(0, 1'b0, 3);
        wr(ADDR_FAULT_EVT, 8'h10);
        rd(ADDR_FAULT_EVT, 8'h00, "fault cleared");
        $display("t_startup done");
    endtask
    task automatic t_undercurrent;
        under_current[3] = 1'b1;
        disconnect_en[3] = 1'b1;
        u_host.cmd(3'b001, 4'h8);
        wait_pw(3, 1'b1, 3);
        cyc(PU + PU / 2);
        chk("uc early off", 8'h01, 8'(port_power[3]));
        wait_pw(3, 1'b0, PU);
        chk("uc fault", 8'h01, 8'(undercurrent_fault[3]));
        u_host.set_modes(4'h0, 4'h8);
        cyc(1);
        chk("uc fault clear", 8'h00, 8'(undercurrent_fault[3]));
        u_host.set_modes(4'h0, 4'h0);
        under_current[3] = 1'b0;
        $display("t_undercurrent done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        arst_n = 1'b0;
        cyc(20);
        arst_n = 1'b1;
        cyc(2);
        t_regs();
        t_short();
        t_overload();
        t_undercurrent();
        t_startup();
        final_report();
    end
endmodule // port_fault_timers_tb_top
bind port_fault_timers port_fault_timers_chk #(.N(N),
    .GATE_HOLD(GATE_HOLD)) u_chk (.ref_clk, .arst_n, .reg_addr, .reg_rd,
    .reg_rdata, .power_on_cmd, .power_off_cmd, .auto_mode, .detect_good,
    .short_circuit, .port_power, .gate_pull_down, .undercurrent_timer_run);

// *** verilog/fault_timer_pkg.sv ***
/*
 * Shared constants for the per-port overload and power-up fault timers.
 * Assumes a 50 MHz reference clock and byte-wide register access.
 */
package fault_timer_pkg;
    localparam int          PORTS           = 4;
    localparam logic [7:0]  ADDR_FAULT_EVT  = 8'h06;
    localparam logic [7:0]  ADDR_DURATIONS  = 8'h16;
    localparam logic [7:0]  DURATIONS_RST   = 8'h00;
    localparam int          DIS_SEL_LSB     = 0;
    localparam int          OVL_SEL_LSB     = 2;
    localparam int          PWRUP_SEL_LSB   = 4;
    localparam int          OVL_BIT_LSB     = 0;
    localparam int          PWRUP_BIT_LSB   = 4;
    localparam int          CLK_MHZ         = 50;
    localparam int          TICK_US         = 100;
    localparam int          TICK_CYCLES     = TICK_US * CLK_MHZ;
    localparam int          GATE_HOLD_US    = 100;
    localparam int          GATE_HOLD_CYC   = GATE_HOLD_US * CLK_MHZ;
    localparam int          CNT_W           = 12;
    localparam int          SLOW_DIV        = 16;
    localparam logic [CNT_W-1:0] OVL_FULL_0 = 12'h0_1F4;
    localparam logic [CNT_W-1:0] STEP_SCALE = 12'h0_002;
    typedef enum logic [1:0] {
        PORT_OFF,
        PORT_POWERUP,
        PORT_ON
    } port_state_t;
endpackage

// *** verilog/overload_counter.sv ***
/*
 * Up/down duty-cycle counter for one port: counts up each tick while
 * overloaded, down every sixteenth tick otherwise, saturating at zero.
 * Assumes tick is a one-cycle pulse from the shared divider.
 */
`timescale 1ns/100ps
module overload_counter
    import fault_timer_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             tick,
    input  wire logic             count_up,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  expired,
    output logic                  at_zero,
    output logic [CNT_W-1:0]      count
);
    logic [CNT_W-1:0] cnt_q;
    logic [3:0]       slow_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            slow_q <= 4'h0;
        end else if (tick) begin
            slow_q <= slow_q + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (tick && count_up && cnt_q < limit) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (tick && !count_up && slow_q == 4'hF
                     && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign expired = (cnt_q >= limit);
    assign at_zero = (cnt_q == '0);
    assign count   = cnt_q;
endmodule // overload_counter

// *** verilog/port_fault_timers.sv ***
/*
 * Per-port overload, power-up and short-circuit timing for a four-port
 * power sourcing controller, with the fault event and duration registers.
 * Assumes comparator inputs are synchronous to ref_clk and that register
 * access arrives as a simple one-cycle read or write strobe.
 */
`timescale 1ns/100ps
// What this block does
// - Overload counter climbs every tick while current exceeds threshold.
// - Expiry with overload still present cuts power and sets overload fault, unless a power-up fault is set instead.
// - Overload duration chosen by bits 3:2 of the durations register.
// - Without overload the counter falls at one sixteenth the rate.
// - Counter stops at zero and never wraps downward.
// - Counter at full count means expiry; port turns off if overload is still present.
// - After expiry port stays off until the counter drains to zero.
// - Manual and semiauto power-on honoured only after counter reaches zero.
// - Auto mode repowers only after detection started at zero count.
// - Power-up timer starts whenever a power-up sequence begins.
// - During power-up the power-up duration is the limit; up/down stays.
// - Undercurrent timer held off until the power-up timer expires.
// - Limit held through whole power-up records a power-up fault.
// - Power-up duration chosen by bits 5:4 of the durations register.
// - No fault when below threshold at power-up end and current is seen.
// - Short circuit pulls gate low at once, released after 100 us.
// - Overload counting continues under reduced foldback limit.
// - Power-up or overload fault removes power in every mode.
module port_fault_timers
    import fault_timer_pkg::*;
#(
    parameter int N          = PORTS,
    parameter int TICK_DIV   = TICK_CYCLES,
    parameter int GATE_HOLD  = GATE_HOLD_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_wdata,
    output logic [7:0]        reg_rdata,
    input  wire logic [N-1:0] power_on_cmd,
    input  wire logic [N-1:0] power_off_cmd,
    input  wire logic [N-1:0] auto_mode,
    input  wire logic [N-1:0] detect_good,
    input  wire logic [N-1:0] port_shutdown,
    input  wire logic [N-1:0] over_threshold,
    input  wire logic [N-1:0] at_hard_limit,
    input  wire logic [N-1:0] short_circuit,
    input  wire logic [N-1:0] under_current,
    input  wire logic [N-1:0] disconnect_en,
    output logic [N-1:0]      port_power,
    output logic [N-1:0]      gate_pull_down,
    output logic [N-1:0]      undercurrent_timer_run,
    output logic [N-1:0]      undercurrent_fault
);
    logic       tick;
    logic [7:0] dur_q;
    logic [7:0] fault_q;
    logic [7:0] rdata_q;

    // The tick sets the resolution of every timer except the gate hold, which counts clocks; the default divider
    // gives a 100 us tick from the 50 MHz clock.
    // shared tick
    tick_divider #(
        .DIV (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tick    (tick)
    );

    logic [1:0] ovl_sel;
    logic [1:0] pwrup_sel;
    logic [1:0] dis_sel;
    assign ovl_sel   = dur_q[OVL_SEL_LSB+1:OVL_SEL_LSB];
    assign pwrup_sel = dur_q[PWRUP_SEL_LSB+1:PWRUP_SEL_LSB];
    assign dis_sel   = dur_q[DIS_SEL_LSB+1:DIS_SEL_LSB];

    // Each overload or power-up select step doubles the window, the disconnect
    // one before STEP_SCALE is added; CNT_W holds the longest setting, so no limit ever wraps.
    logic [CNT_W-1:0] ovl_limit;
    logic [CNT_W-1:0] pwrup_limit;
    logic [CNT_W-1:0] dis_limit;
    assign ovl_limit   = OVL_FULL_0 << ovl_sel;
    assign pwrup_limit = (OVL_FULL_0 + STEP_SCALE) << pwrup_sel;
    assign dis_limit   = (OVL_FULL_0 << dis_sel) + STEP_SCALE;

    logic [N-1:0] set_ovl;
    logic [N-1:0] set_pwrup;
    logic [N-1:0] set_dis;

    // One copy of the counters and state per port; the ports share only
    // the tick and the duration fields.
    genvar p;
    generate
        for (p = 0; p < N; p++) begin : g_port
            port_state_t      st_q;
            logic [CNT_W-1:0] pu_q;
            logic             pu_run_q;
            logic             lim_all_q;
            logic [CNT_W-1:0] dis_q;
            logic [15:0]      gate_q;
            logic             drained_q;
            logic             expired;
            logic             at_zero;
            logic [CNT_W-1:0] limit_now;

            assign limit_now = pu_run_q ? pwrup_limit : ovl_limit;

            overload_counter u_cnt (
                .ref_clk  (ref_clk),
                .arst_n   (arst_n),
                .tick     (tick),
                .count_up (over_threshold[p] && st_q != PORT_OFF),
                .limit    (limit_now),
                .expired  (expired),
                .at_zero  (at_zero),
                .count    ()
            );

            // A command that lands while the counter still drains is
            // dropped, not queued, so the host has to issue it again.
            // arm only once drained
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    drained_q <= 1'b0;
                end else if (st_q != PORT_OFF) begin
                    drained_q <= 1'b0;
                end else if (at_zero) begin
                    drained_q <= 1'b1;
                end
            end

            logic start_req;
            assign start_req = drained_q && at_zero &&
                (auto_mode[p] ? detect_good[p] : power_on_cmd[p]);

            // Expiry alone is no fault; the overload must still be present.
            logic trip;
            assign trip = expired && over_threshold[p];

            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    st_q <= PORT_OFF;
                end else begin
                    case (st_q)
                        PORT_OFF: begin
                            if (start_req && !port_shutdown[p]) begin
                                st_q <= PORT_POWERUP;
                            end
                        end
                        // Removal outranks the end of power-up, so a trip on
                        // the last power-up tick is never lost.
                        PORT_POWERUP, PORT_ON: begin
                            if (trip || power_off_cmd[p] ||
                                port_shutdown[p] || set_dis[p]) begin
                                st_q <= PORT_OFF;
                            end else if (st_q == PORT_POWERUP &&
                                         !pu_run_q) begin
                                st_q <= PORT_ON;
                            end
                        end
                        default: st_q <= PORT_OFF;
                    endcase
                end
            end

            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    pu_q      <= '0;
                    pu_run_q  <= 1'b0;
                    lim_all_q <= 1'b0;
                end else if (st_q == PORT_OFF && start_req) begin
                    pu_q      <= '0;
                    pu_run_q  <= 1'b1;
                    lim_all_q <= 1'b1;
                end else if (st_q == PORT_OFF) begin
                    pu_run_q  <= 1'b0;
                end else if (pu_run_q && tick) begin
                    pu_q      <= pu_q + 1'b1;
                    lim_all_q <= lim_all_q & at_hard_limit[p];
                    // Close the window one tick after the counter can reach
                    // the power-up limit, so an expiry on that last tick is
                    // still judged against the power-up limit and flag.
                    if (pu_q >= pwrup_limit) begin
                        pu_run_q <= 1'b0;
                    end
                end
            end

            assign set_pwrup[p] = trip && st_q != PORT_OFF &&
                                  pu_run_q && lim_all_q;
            assign set_ovl[p]   = trip && st_q != PORT_OFF &&
                                  !set_pwrup[p];

            assign undercurrent_timer_run[p] = st_q == PORT_ON &&
                disconnect_en[p] && under_current[p];

            // The count restarts from zero whenever current returns.
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    dis_q <= '0;
                end else if (!undercurrent_timer_run[p]) begin
                    dis_q <= '0;
                end else if (tick && dis_q < dis_limit) begin
                    dis_q <= dis_q + 1'b1;
                end
            end

            assign set_dis[p] = undercurrent_timer_run[p] &&
                                dis_q >= dis_limit;

            // A short on an unpowered port is ignored, the gate being off
            // already; a new short while held restarts the hold.
            // short-circuit gate pull-down and release
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    gate_q <= 16'h0000;
                end else if (short_circuit[p] && st_q != PORT_OFF) begin
                    gate_q <= 16'(GATE_HOLD);
                end else if (gate_q != 16'h0000) begin
                    gate_q <= gate_q - 16'h0001;
                end
            end

            // Power follows the state register with no further delay.
            assign port_power[p]     = st_q != PORT_OFF;
            assign gate_pull_down[p] = gate_q != 16'h0000;

            // Disconnect fault is sticky until shutdown; a set in the same
            // cycle as the clear wins, so no event is lost.
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    undercurrent_fault[p] <= 1'b0;
                end else if (set_dis[p]) begin
                    undercurrent_fault[p] <= 1'b1;
                end else if (port_shutdown[p]) begin
                    undercurrent_fault[p] <= 1'b0;
                end
            end
        end
    endgenerate

    // Only the duration register takes whole bytes; a write to any other
    // address leaves it untouched.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dur_q <= DURATIONS_RST;
        end else if (reg_wr && reg_addr == ADDR_DURATIONS) begin
            dur_q <= reg_wdata;
        end
    end

    // Writing a one clears a fault bit; writing a zero leaves it alone.
    // sticky fault bits, set beats clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_q <= 8'h00;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (set_ovl[i]) begin
                    fault_q[OVL_BIT_LSB+i] <= 1'b1;
                end else if (port_shutdown[i] || (reg_wr &&
                    reg_addr == ADDR_FAULT_EVT &&
                    reg_wdata[OVL_BIT_LSB+i])) begin
                    fault_q[OVL_BIT_LSB+i] <= 1'b0;
                end
                if (set_pwrup[i]) begin
                    fault_q[PWRUP_BIT_LSB+i] <= 1'b1;
                end else if (port_shutdown[i] || (reg_wr &&
                    reg_addr == ADDR_FAULT_EVT &&
                    reg_wdata[PWRUP_BIT_LSB+i])) begin
                    fault_q[PWRUP_BIT_LSB+i] <= 1'b0;
                end
            end
        end
    end

    // Read data are registered and hold until the next read strobe, so a
    // slow host may sample them late.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_FAULT_EVT: rdata_q <= fault_q;
                ADDR_DURATIONS: rdata_q <= dur_q;
                default:        rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;
endmodule // port_fault_timers

// *** verilog/tick_divider.sv ***
/*
 * Free-running divider producing a one-cycle tick every DIV clocks.
 * Assumes a single synchronous clock domain.
 */
`timescale 1ns/100ps
module tick_divider #(
    parameter int DIV = 5000
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    output logic      tick
);
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tick = (cnt_q == 16'(DIV - 1));
endmodule // tick_divider
